// File: src/qtm_top.sv
// four-channel timer with apb registers, compare, pwm and capture
//
// What this block does
// - mode field 00 makes a flexible channel an auto reload timer
// - auto reload: overflow raises overflow request and reloads from reload reg
// - auto reload mode never changes the output level
// - compare mode match updates output: 00 low, 01 high, 10 toggle
// - compare mode: overflow request on overflow, event request on match
// - pwm period from reload register, first portion from compare register
// - pwm policy 01: high while counter at or below compare, else low
// - pwm policy 00: low while counter at or below compare, else high
// - every flexible mode raises overflow request on counter overflow
// - capture copies counter into compare register on selected input edge
// - capture policy: 00 none, 01 rising, 10 falling, 11 both
// - capture raises event request per trigger, plus overflow request
// - channels 2 and 3 are auto reload timers only
// - each channel picks sys clock, timebase/2..32, or external edge
// - writing one to start or stop bits starts or stops channels
// - start register reads run state; stop bit clears run bit
// - external clock sampled, counter steps two edges after the edge
// - capture mode releases the output pin and uses input as trigger
// - compare and pwm modes drive the output pin
// - compare output changes on the count pulse after the match
// - pwm output changes on the count pulse after condition change
// - a software write to the output level wins over a timer update
`timescale 1ns/1ps
module qtm_top #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qtm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [qtm_pkg::NUM_CH-1:0] ext_clk_pin,
  input wire logic [qtm_pkg::NUM_FLEX-1:0] capture_input_pin,
  output logic [qtm_pkg::NUM_FLEX-1:0] timer_output_pin_level,
  output logic [qtm_pkg::NUM_FLEX-1:0] timer_output_oe,
  output logic [qtm_pkg::NUM_CH-1:0] overflow_irq,
  output logic [qtm_pkg::NUM_FLEX-1:0] match_capture_irq
);

  localparam int NCH = qtm_pkg::NUM_CH;
  localparam int NFX = qtm_pkg::NUM_FLEX;

  // the data bus is 32 bits, so a counter wider than that cannot be read
  if (CNT_W < 2 || CNT_W > 32)
  begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end

  logic [qtm_pkg::CTRL_W-1:0] ctrl_ff [NCH];
  logic [CNT_W-1:0] cnt_ff [NCH];
  logic [CNT_W-1:0] reload_ff [NCH];
  logic [CNT_W-1:0] cmp_ff [NCH];
  logic [1:0] policy_ff [NFX];
  logic [NFX-1:0] outlvl_ff;
  logic [NCH-1:0] run_ff;
  logic [qtm_pkg::PRE_W-1:0] pre_ff;
  logic [NCH-1:0] ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic [NFX-1:0] cin_s1_ff, cin_s2_ff, cin_s3_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [NFX-1:0] tout_ff, toe_ff, evt_ff;
  logic [NCH-1:0] ovf_ff;

  logic wr_w;
  logic [1:0] wch_w;
  logic [4:0] woff_w;
  logic [NCH-1:0] tick_w, ovf_w, cnt_wr_w;
  logic [NFX-1:0] match_w, upd_w, trig_w, lvl_wr_w;
  logic [CNT_W-1:0] nxt_cnt [NCH];
  qtm_pkg::qtm_mode_t mode_w [NCH];

  // picks the count tick for one channel from its clock selection
  function automatic logic sel_tick(
    input logic [2:0] sel,
    input logic [qtm_pkg::PRE_W-1:0] pre,
    input logic rise,
    input logic fall
  );
    logic t;
    t = 1'b0;
    case (qtm_pkg::qtm_clk_t'(sel))
      qtm_pkg::cks_sys: t = 1'b1;
      qtm_pkg::cks_tb2: t = pre[0];
      qtm_pkg::cks_tb4: t = &pre[1:0];
      qtm_pkg::cks_tb8: t = &pre[2:0];
      qtm_pkg::cks_tb16: t = &pre[3:0];
      qtm_pkg::cks_tb32: t = &pre[4:0];
      qtm_pkg::cks_ext_rise: t = rise;
      qtm_pkg::cks_ext_fall: t = fall;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, write lands at the end of access phase
  assign wr_w = psel & penable & pready_ff & pwrite;
  assign wch_w = paddr[qtm_pkg::CH_LSB+1:qtm_pkg::CH_LSB];
  assign woff_w = paddr[qtm_pkg::CH_LSB-1:0];

  // per-channel tick, overflow, next count and pin events
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      // channels 2 and 3 ignore their mode bits and only auto reload
      mode_w[i] = (i < NFX) ?
        qtm_pkg::qtm_mode_t'(ctrl_ff[i][qtm_pkg::MODE_LSB +: 2]) :
        qtm_pkg::auto_reload_op;
      tick_w[i] = run_ff[i] & sel_tick(
        ctrl_ff[i][qtm_pkg::CLK_LSB +: 3], pre_ff,
        ext_s2_ff[i] & ~ext_s3_ff[i],
        ~ext_s2_ff[i] & ext_s3_ff[i]);
      ovf_w[i] = tick_w[i] & (&cnt_ff[i]);
      nxt_cnt[i] = ovf_w[i] ? reload_ff[i] : cnt_ff[i] + 1'b1;
      cnt_wr_w[i] = wr_w && !paddr[7] && wch_w == 2'(i) &&
        woff_w == qtm_pkg::REG_COUNT;
    end
    for (int i = 0; i < NFX; i++)
    begin
      match_w[i] = tick_w[i] && nxt_cnt[i] == cmp_ff[i];
      // the match is acted on at the next count pulse
      upd_w[i] = tick_w[i] && cnt_ff[i] == cmp_ff[i];
      trig_w[i] = mode_w[i] == qtm_pkg::input_capture_op &&
        ((policy_ff[i][0] & cin_s2_ff[i] & ~cin_s3_ff[i]) |
         (policy_ff[i][1] & ~cin_s2_ff[i] & cin_s3_ff[i]));
      lvl_wr_w[i] = wr_w && !paddr[7] && wch_w == 2'(i) &&
        woff_w == qtm_pkg::REG_OUTLVL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin sampling: three stages so edges are seen two clocks after sampling
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ext_s1_ff <= '0;
      ext_s2_ff <= '0;
      ext_s3_ff <= '0;
      cin_s1_ff <= '0;
      cin_s2_ff <= '0;
      cin_s3_ff <= '0;
    end
    else
    begin
      ext_s1_ff <= ext_clk_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      cin_s1_ff <= capture_input_pin;
      cin_s2_ff <= cin_s1_ff;
      cin_s3_ff <= cin_s2_ff;
    end
  end

  // free-running timebase prescaler shared by all channels
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + 1'b1;
  end

  // run bits: start and stop are separate words, so they never collide
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      run_ff <= qtm_pkg::RUN_RST;
    else if (wr_w && paddr == qtm_pkg::ADDR_START)
      run_ff <= run_ff | pwdata[NCH-1:0];
    else if (wr_w && paddr == qtm_pkg::ADDR_STOP)
      run_ff <= run_ff & ~pwdata[NCH-1:0];
  end

  // configuration registers written by software
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ctrl_ff[i] <= qtm_pkg::CTRL_RST;
        reload_ff[i] <= '0;
      end
      for (int i = 0; i < NFX; i++)
        policy_ff[i] <= qtm_pkg::POLICY_RST;
    end
    else if (wr_w && !paddr[7])
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (wch_w == 2'(i) && woff_w == qtm_pkg::REG_CTRL)
          ctrl_ff[i] <= pwdata[qtm_pkg::CTRL_W-1:0];
        if (wch_w == 2'(i) && woff_w == qtm_pkg::REG_RELOAD)
          reload_ff[i] <= pwdata[CNT_W-1:0];
      end
      for (int i = 0; i < NFX; i++)
        if (wch_w == 2'(i) && woff_w == qtm_pkg::REG_POLICY)
          policy_ff[i] <= pwdata[1:0];
    end
  end

  // counters: software load has priority, else step or reload on a tick
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      for (int i = 0; i < NCH; i++)
        cnt_ff[i] <= '0;
    else
      for (int i = 0; i < NCH; i++)
        if (cnt_wr_w[i])
          cnt_ff[i] <= pwdata[CNT_W-1:0];
        else if (tick_w[i])
          cnt_ff[i] <= nxt_cnt[i];
  end

  // compare/capture register: a capture beats a software write
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      for (int i = 0; i < NCH; i++)
        cmp_ff[i] <= '0;
    else
      for (int i = 0; i < NCH; i++)
        if (i < NFX && trig_w[i % NFX])
          cmp_ff[i] <= cnt_ff[i];
        else if (wr_w && !paddr[7] && wch_w == 2'(i) &&
                 woff_w == qtm_pkg::REG_CMP)
          cmp_ff[i] <= pwdata[CNT_W-1:0];
  end

  // output level bit; a software write holds until the next update event
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      outlvl_ff <= '0;
    else
      for (int i = 0; i < NFX; i++)
        if (lvl_wr_w[i])
          outlvl_ff[i] <= pwdata[0];
        else if (mode_w[i] == qtm_pkg::compare_output_op && upd_w[i])
          case (policy_ff[i])
            qtm_pkg::POL_LOW: outlvl_ff[i] <= 1'b0;
            qtm_pkg::POL_HIGH: outlvl_ff[i] <= 1'b1;
            qtm_pkg::POL_TOGGLE: outlvl_ff[i] <= ~outlvl_ff[i];
            default: outlvl_ff[i] <= outlvl_ff[i];
          endcase
        else if (mode_w[i] == qtm_pkg::pwm_op && tick_w[i])
          case (policy_ff[i])
            qtm_pkg::POL_LOW: outlvl_ff[i] <= cnt_ff[i] > cmp_ff[i];
            qtm_pkg::POL_HIGH: outlvl_ff[i] <= cnt_ff[i] <= cmp_ff[i];
            default: outlvl_ff[i] <= outlvl_ff[i];
          endcase
  end

  // pins: level and enable follow the mode; capture releases the pin
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tout_ff <= '0;
      toe_ff <= '0;
    end
    else
      for (int i = 0; i < NFX; i++)
      begin
        tout_ff[i] <= outlvl_ff[i];
        toe_ff[i] <= mode_w[i] != qtm_pkg::input_capture_op;
      end
  end

  // interrupt request pulses, one clock each
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ovf_ff <= '0;
      evt_ff <= '0;
    end
    else
    begin
      ovf_ff <= ovf_w;
      for (int i = 0; i < NFX; i++)
        evt_ff[i] <= (mode_w[i] == qtm_pkg::compare_output_op &&
          match_w[i]) || trig_w[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb read path, captured in the setup cycle so pready can be a flop
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      if (psel && !penable)
      begin
        if (paddr == qtm_pkg::ADDR_START)
          prdata_ff <= 32'(run_ff);
        else if (paddr == qtm_pkg::ADDR_STOP)
          prdata_ff <= '0;
        else if (!paddr[7] && woff_w == qtm_pkg::REG_CTRL)
          prdata_ff <= 32'(ctrl_ff[wch_w] &
            (wch_w < 2'(NFX) ? 5'h1F : 5'h1C));
        else if (!paddr[7] && woff_w == qtm_pkg::REG_COUNT)
          prdata_ff <= 32'(cnt_ff[wch_w]);
        else if (!paddr[7] && woff_w == qtm_pkg::REG_RELOAD)
          prdata_ff <= 32'(reload_ff[wch_w]);
        else if (!paddr[7] && woff_w == qtm_pkg::REG_CMP)
          prdata_ff <= 32'(cmp_ff[wch_w]);
        else if (!paddr[7] && !wch_w[1] && woff_w == qtm_pkg::REG_POLICY)
          prdata_ff <= 32'(policy_ff[wch_w[0]]);
        else if (!paddr[7] && !wch_w[1] && woff_w == qtm_pkg::REG_OUTLVL)
          prdata_ff <= 32'(outlvl_ff[wch_w[0]]);
        else
          pslverr_ff <= 1'b1;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign timer_output_pin_level = tout_ff;
  assign timer_output_oe = toe_ff;
  assign overflow_irq = ovf_ff;
  assign match_capture_irq = evt_ff;

  //////////////////////////////////////////////////////////////////////////
  // checks on channels 0 and 1 (flexible) and channel 2 (auto reload only)
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  ovf_reload_a: assert property (ovf_w[2] && !cnt_wr_w[2] |=>
    cnt_ff[2] == $past(reload_ff[2]) && overflow_irq[2])
    else $error("overflow did not reload or raise request");
  art_hold_a: assert property (
    mode_w[0] == qtm_pkg::auto_reload_op && !lvl_wr_w[0] |=>
    outlvl_ff[0] == $past(outlvl_ff[0]))
    else $error("auto reload mode changed output level");
  cmo_set_a: assert property (
    mode_w[0] == qtm_pkg::compare_output_op && upd_w[0] &&
    policy_ff[0] == qtm_pkg::POL_HIGH && !lvl_wr_w[0] |=> ##1
    timer_output_pin_level[0])
    else $error("compare set policy did not drive high");
  cmo_event_a: assert property (
    mode_w[0] == qtm_pkg::compare_output_op && match_w[0] |=>
    match_capture_irq[0])
    else $error("compare match missed event request");
  pwm_high_a: assert property (
    mode_w[1] == qtm_pkg::pwm_op && tick_w[1] && !lvl_wr_w[1] &&
    policy_ff[1] == qtm_pkg::POL_HIGH |=>
    outlvl_ff[1] == ($past(cnt_ff[1]) <= $past(cmp_ff[1])))
    else $error("pwm high policy level wrong");
  pwm_low_a: assert property (
    mode_w[1] == qtm_pkg::pwm_op && tick_w[1] && !lvl_wr_w[1] &&
    policy_ff[1] == qtm_pkg::POL_LOW |=>
    outlvl_ff[1] == ($past(cnt_ff[1]) > $past(cmp_ff[1])))
    else $error("pwm low policy level wrong");
  capture_copy_a: assert property (trig_w[0] |=>
    cmp_ff[0] == $past(cnt_ff[0]) && match_capture_irq[0])
    else $error("capture did not copy counter");
  cap_pins_a: assert property (
    mode_w[0] == qtm_pkg::input_capture_op ##1
    mode_w[0] == qtm_pkg::input_capture_op |-> !timer_output_oe[0])
    else $error("capture mode still drives output pin");
  stop_hold_a: assert property (!run_ff[2] && !cnt_wr_w[2] |=>
    $stable(cnt_ff[2]))
    else $error("stopped counter moved");
  start_run_a: assert property (
    wr_w && paddr == qtm_pkg::ADDR_START && pwdata[1] |=> run_ff[1])
    else $error("start write did not set run bit");
  ext_delay_a: assert property (
    run_ff[2] && !cnt_wr_w[2] && !(&cnt_ff[2]) &&
    ctrl_ff[2][qtm_pkg::CLK_LSB +: 3] == qtm_pkg::cks_ext_rise &&
    !ext_s2_ff[2] && ext_s1_ff[2] |=>
    ##1 cnt_ff[2] == $past(cnt_ff[2], 2) + 1'b1)
    else $error("external edge did not step counter two clocks later");

endmodule

// File: src/qtm_pkg.sv
// shared constants and types for the quad timer block
package qtm_pkg;

  localparam int NUM_CH = 4;
  localparam int NUM_FLEX = 2;
  localparam int ADDR_W = 8;
  localparam int CH_LSB = 5;
  localparam int CTRL_W = 5;
  localparam int MODE_LSB = 0;
  localparam int CLK_LSB = 2;
  localparam int PRE_W = 5;

  // per-channel register offsets inside a 32-byte channel window
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_COUNT = 5'h04;
  localparam logic [4:0] REG_RELOAD = 5'h08;
  localparam logic [4:0] REG_CMP = 5'h0C;
  localparam logic [4:0] REG_POLICY = 5'h10;
  localparam logic [4:0] REG_OUTLVL = 5'h14;

  // global registers
  localparam logic [7:0] ADDR_START = 8'h80;
  localparam logic [7:0] ADDR_STOP = 8'h84;

  // reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [1:0] POLICY_RST = 2'h0;
  localparam logic [3:0] RUN_RST = 4'h0;

  typedef enum logic [1:0] {
    auto_reload_op = 2'b00,
    compare_output_op = 2'b01,
    pwm_op = 2'b10,
    input_capture_op = 2'b11
  } qtm_mode_t;

  typedef enum logic [2:0] {
    cks_sys = 3'h0,
    cks_tb2 = 3'h1,
    cks_tb4 = 3'h2,
    cks_tb8 = 3'h3,
    cks_tb16 = 3'h4,
    cks_tb32 = 3'h5,
    cks_ext_rise = 3'h6,
    cks_ext_fall = 3'h7
  } qtm_clk_t;

  // level policy codes; capture mode reads bit 0 as rise, bit 1 as fall
  localparam logic [1:0] POL_LOW = 2'b00;
  localparam logic [1:0] POL_HIGH = 2'b01;
  localparam logic [1:0] POL_TOGGLE = 2'b10;

endpackage

// File: verif/qtm_pins_model.sv
// pin-side model: external count clocks and capture inputs
`timescale 1ns/1ps
module qtm_pins_model (
  input wire logic ref_clk,
  output logic [qtm_pkg::NUM_CH-1:0] ext_clk_pin,
  output logic [qtm_pkg::NUM_FLEX-1:0] capture_input_pin
);
  // both pin groups idle low until a task moves them
  initial
  begin
    ext_clk_pin = 4'h0;
    capture_input_pin = 2'h0;
  end
  // high phases last three system clocks and low phases at least three, above the two-clock minimum
  task automatic ext_pulse(input int ch, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      ext_clk_pin[ch] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext_clk_pin[ch] <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  // the level is held long enough for the two-sample edge detector
  task automatic cap_level(input int ch, input logic v);
    @(posedge ref_clk);
    capture_input_pin[ch] <= v;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// File: verif/testbench.sv
// self-checking bench for the quad timer block
`timescale 1ns/1ps
module testbench;
  logic ref_clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ext_clk_pin;
  logic [1:0] cap_pin;
  logic [1:0] tol;
  logic [1:0] toe;
  logic [3:0] ovf;
  logic [1:0] mci;
  logic [31:0] rdata;
  logic rerr;
  int fail_count;
  int tests_run;
  int ov_cnt [4];
  int mc_cnt [2];
  logic [72:0] rows [9];
  logic [15:0] tb_rows [2];
  logic [3:0] cmp_rows [4];
  logic [10:0] pwm_rows [4];
  logic [19:0] cap_rows [4];
  qtm_top #(.CNT_W(8)) qtm_top_inst (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_pin(ext_clk_pin), .capture_input_pin(cap_pin),
    .timer_output_pin_level(tol), .timer_output_oe(toe),
    .overflow_irq(ovf), .match_capture_irq(mci));
  qtm_pins_model qtm_pins_model_inst (.ref_clk(ref_clk),
    .ext_clk_pin(ext_clk_pin), .capture_input_pin(cap_pin));
  ////////////////////////////////////////////////////////////////////////////
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  // irq pulses last one cycle, so they are tallied on every edge
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < 4; i++)
      if (ovf[i] === 1'b1) ov_cnt[i]++;
    for (int i = 0; i < 2; i++)
      if (mci[i] === 1'b1) mc_cnt[i]++;
  end
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // the request stands until pready is sampled high; read data taken there
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      $display("mismatch at %0t: bus timeout", $time);
      results();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdata, e);
  endtask
  function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
    return {ch[2:0], off};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fail_count = 0;
    tests_run = 0;
    ov_cnt = '{0, 0, 0, 0};
    mc_cnt = '{0, 0};
    // rows: address, write data, expected read, expected error
    rows = '{{ra(0, 5'h00), 32'hFFFFFFFF, 32'h1F, 1'b0},
      {ra(1, 5'h08), 32'hFFFFFFAB, 32'hAB, 1'b0},
      {ra(0, 5'h0C), 32'h12, 32'h12, 1'b0},
      {ra(1, 5'h10), 32'hFF, 32'h3, 1'b0},
      {ra(0, 5'h14), 32'hFF, 32'h1, 1'b0},
      {ra(2, 5'h00), 32'h1F, 32'h1C, 1'b0},
      {8'h88, 32'h5, 32'h0, 1'b1},
      {8'h84, 32'h0, 32'h0, 1'b0},
      {8'h80, 32'h0, 32'h0, 1'b0}};
    cmp_rows = '{4'b0101, 4'b1010, 4'b0010, 4'b1001};
    pwm_rows = '{{2'b01, 8'h03, 1'b1}, {2'b01, 8'h08, 1'b0},
      {2'b00, 8'h03, 1'b0}, {2'b00, 8'h08, 1'b1}};
    cap_rows = '{{2'b01, 8'h42, 1'b1, 8'h42, 1'b1},
      {2'b10, 8'h55, 1'b0, 8'h55, 1'b1},
      {2'b00, 8'h66, 1'b1, 8'h55, 1'b0},
      {2'b11, 8'h77, 1'b0, 8'h77, 1'b1}};
    // ch3 control word, expected count after 40 running cycles
    tb_rows = '{{8'h00, 8'h28}, {8'h0C, 8'h05}};
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    check({ovf, mci, pready}, 32'h0);
    // register table rows, write then read back
    foreach (rows[i])
    begin
      apb(1'b1, rows[i][72:65], rows[i][64:33]);
      rchk(rows[i][72:65], rows[i][32:1]);
      check(rerr, rows[i][0]);
    end
    $display("test registers done");
    // several channels start and stop in one write, ch2 on external rise
    apb(1'b1, 8'h80, 32'hF);
    rchk(8'h80, 32'hF);
    apb(1'b1, 8'h84, 32'hF);
    rchk(8'h80, 32'h0);
    apb(1'b1, ra(2, 5'h00), 32'h18);
    apb(1'b1, ra(2, 5'h08), 32'h10);
    apb(1'b1, ra(2, 5'h04), 32'hFE);
    apb(1'b1, 8'h80, 32'h4);
    ov_cnt[2] = 0;
    qtm_pins_model_inst.ext_pulse(2, 3);
    repeat (3) @(posedge ref_clk);
    rchk(ra(2, 5'h04), 32'h11);
    check(ov_cnt[2], 32'h1);
    apb(1'b1, 8'h84, 32'h4);
    qtm_pins_model_inst.ext_pulse(2, 2);
    rchk(ra(2, 5'h04), 32'h11);
    // ch3 on system clock, then timebase/8; start to stop spans 40 cycles
    foreach (tb_rows[i])
    begin
      apb(1'b1, ra(3, 5'h00), {24'h0, tb_rows[i][15:8]});
      apb(1'b1, ra(3, 5'h04), 32'h0);
      apb(1'b1, 8'h80, 32'h8);
      repeat (37) @(posedge ref_clk);
      apb(1'b1, 8'h84, 32'h8);
      rchk(ra(3, 5'h04), {24'h0, tb_rows[i][7:0]});
    end
    $display("test auto reload done");
    // compare output on ch0: each policy, level moves one tick after match
    apb(1'b1, ra(0, 5'h00), 32'h19);
    apb(1'b1, ra(0, 5'h0C), 32'h2);
    apb(1'b1, 8'h80, 32'h1);
    foreach (cmp_rows[i])
    begin
      apb(1'b1, ra(0, 5'h10), {30'h0, cmp_rows[i][3:2]});
      apb(1'b1, ra(0, 5'h14), {31'h0, cmp_rows[i][1]});
      apb(1'b1, ra(0, 5'h04), 32'h1);
      mc_cnt[0] = 0;
      qtm_pins_model_inst.ext_pulse(0, 1);
      check(tol[0], cmp_rows[i][1]);
      check(mc_cnt[0], 32'h1);
      qtm_pins_model_inst.ext_pulse(0, 1);
      check({toe[0], tol[0]}, {1'b1, cmp_rows[i][0]});
    end
    $display("test compare done");
    // pwm on ch1 against compare 5, then period wrap from reload
    apb(1'b1, ra(1, 5'h00), 32'h1A);
    apb(1'b1, ra(1, 5'h0C), 32'h5);
    apb(1'b1, 8'h80, 32'h2);
    foreach (pwm_rows[i])
    begin
      apb(1'b1, ra(1, 5'h10), {30'h0, pwm_rows[i][10:9]});
      apb(1'b1, ra(1, 5'h04), {24'h0, pwm_rows[i][8:1]});
      qtm_pins_model_inst.ext_pulse(1, 1);
      check({toe[1], tol[1]}, {1'b1, pwm_rows[i][0]});
    end
    apb(1'b1, ra(1, 5'h14), 32'h0);
    repeat (2) @(posedge ref_clk);
    check(tol[1], 1'b0);
    apb(1'b1, ra(1, 5'h08), 32'h20);
    apb(1'b1, ra(1, 5'h04), 32'hFF);
    ov_cnt[1] = 0;
    qtm_pins_model_inst.ext_pulse(1, 1);
    check(tol[1], 1'b1);
    rchk(ra(1, 5'h04), 32'h20);
    check(ov_cnt[1], 32'h1);
    $display("test pwm done");
    // capture on ch0 for each trigger selection; pins are released
    apb(1'b1, ra(0, 5'h00), 32'h1B);
    foreach (cap_rows[i])
    begin
      apb(1'b1, ra(0, 5'h10), {30'h0, cap_rows[i][19:18]});
      apb(1'b1, ra(0, 5'h04), {24'h0, cap_rows[i][17:10]});
      mc_cnt[0] = 0;
      qtm_pins_model_inst.cap_level(0, cap_rows[i][9]);
      rchk(ra(0, 5'h0C), {24'h0, cap_rows[i][8:1]});
      check(mc_cnt[0], {31'h0, cap_rows[i][0]});
      check(toe[0], 1'b0);
    end
    $display("test capture done");
    // a second reset in mid-run clears run bits and output level
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    check({tol, toe, ovf, mci}, 32'h0);
    // oe rises one clock after release since mode 00 drives the pin
    repeat (2) @(posedge ref_clk);
    check(toe, 2'b11);
    rchk(8'h80, 32'h0);
    check({tol, ovf, mci}, 32'h0);
    $display("test reset done");
    results();
  end
endmodule
